// [battery_monitor_link_config_status_tb.sv]
// Self-checking testbench for the link configuration and status block
`timescale 1ns/100ps
module battery_monitor_link_config_status_tb;
  logic clk = 1'b0, reset_n = 1'b0, hold_low = 1'b0, cmd_valid = 1'b0, cmd_addr_match = 1'b0;
  logic wr_valid = 1'b0, recall_valid = 1'b0, power_switch_n = 1'b1;
  logic [7:0] cmd_opcode = 8'h00, cmd_addr = 8'h00, wr_addr = 8'h00, wr_data = 8'h00;
  logic [7:0] rd_addr = 8'h00, recall_byte = 8'h00, rd_data, read_addr_opcode, crc, cfg = 8'h00;
  logic line_in, general_pin_in, general_pin_oe, general_pin_out, swap_accepted, sleeping, line_reset, copy_busy;
  logic arm = 1'b0, bl0 = 1'b0, bl1 = 1'b0, latch = 1'b1, general_pin_drive_sense = 1'b1;
  logic [63:0] net_address;
  logic [55:0] id;
  int n_fail = 0, n_tests = 0, i, n_swaps = 0;
  always #5 clk = ~clk;
  // The swap pulse lasts one cycle, so catch it wherever it lands
  always @(posedge clk) if (swap_accepted === 1'b1) n_swaps++;
  monitor_link_cfg #(.sleep_cycles(500), .copy_len(20)) dut (.clk(clk), .reset_n(reset_n),
    .line_in(line_in), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_addr_match(cmd_addr_match),
    .cmd_addr(cmd_addr), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .recall_valid(recall_valid), .recall_byte(recall_byte),
    .power_switch_n(power_switch_n), .general_pin_in(general_pin_in), .general_pin_oe(general_pin_oe),
    .general_pin_out(general_pin_out), .net_address(net_address), .read_addr_opcode(read_addr_opcode),
    .swap_accepted(swap_accepted), .sleeping(sleeping), .line_reset(line_reset), .copy_busy(copy_busy));
  host_line_model line_model (.hold_low(hold_low), .pin_oe(general_pin_oe), .pin_out(general_pin_out),
    .line_level(line_in), .pin_level(general_pin_in));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic check_val(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : check_val
  task automatic check_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_addr = a;
    #1;
    check_val(rd_data & m, e & m);
  endtask : check_rd
  // Reserved bits are masked off since their read value is not defined
  task automatic check_all();
    check_rd(8'h01, cfg, 8'h38);
    check_rd(8'h07, {1'b0, arm, 4'h0, bl1, bl0}, 8'hc3);
    check_rd(8'h08, {latch, general_pin_drive_sense, 6'h00}, 8'hc0);
    check_val(general_pin_oe, !general_pin_drive_sense);
    check_val(general_pin_out, 1'b0);
  endtask : check_all
  task automatic cmd(input logic [7:0] op, input logic m, input logic [7:0] a);
    cmd_opcode = op;
    cmd_addr_match = m;
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_addr = a;
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    @(negedge clk);
    if (a == 8'h07) arm = arm | d[6];
    if (a == 8'h08) general_pin_drive_sense = d[6];
    if (a == 8'h08 && d[7]) latch = 1'b1;
  endtask : wr
  task automatic recall(input logic [7:0] b);
    recall_byte = b;
    recall_valid = 1'b1;
    @(negedge clk);
    recall_valid = 1'b0;
    @(negedge clk);
    cfg = b & 8'h38;
  endtask : recall
  // Long low: reset pulse, sleep entry when enabled, pin release; then presence step
  task automatic bus_reset();
    hold_low = 1'b1;
    repeat (12010) @(negedge clk);
    check_val(line_reset, 1'b1);
    check_val(sleeping, cfg[5]);
    general_pin_drive_sense = 1'b1;
    check_all();
    hold_low = 1'b0;
    repeat (2) @(negedge clk);
    check_val(line_reset, 1'b0);
    check_val(sleeping, 1'b0);
    cmd(8'h00, 1'b0, 8'h00);
  endtask : bus_reset
  task automatic lock_blk(input logic [7:0] a, input logic armed);
    if (armed) wr(8'h07, 8'h40 | (8'($urandom) & 8'h3c));
    bus_reset();
    cmd(8'hcc, 1'b0, 8'h00);
    cmd(8'h6a, 1'b0, a);
    if (arm) begin
      bl1 = bl1 | a[4];
      bl0 = bl0 | !a[4];
      arm = 1'b0;
    end
    check_all();
  endtask : lock_blk
  initial begin
    void'($urandom(80));
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check_all();
    check_rd(8'h02, 8'hff, 8'hff);
    id = {monitor_link_pkg::serial_number, monitor_link_pkg::family_code};
    crc = 8'h00;
    for (i = 0; i < 56; i++) begin
      crc = (crc >> 1) ^ ((crc[0] ^ id[i]) ? 8'h8c : 8'h00);
    end
    check_val(net_address, {crc, id});
    wr(8'h08, 8'($urandom) & 8'h1f);
    check_all();
    bus_reset();
    cmd(8'haa, 1'b1, 8'h00);
    check_val(n_swaps, 0);
    check_rd(8'h08, 8'h00, 8'h20);
    for (i = 0; i < 8; i++) begin
      recall((8'($urandom) & 8'hc7) | 8'(i << 3));
      wr(8'h01, ~recall_byte);
      check_rd(8'h01, cfg, 8'h38);
      check_val(read_addr_opcode, cfg[4] ? 8'h39 : 8'h33);
    end
    bus_reset();
    cmd(8'haa, 1'b1, 8'h00);
    check_val(n_swaps, 1);
    check_rd(8'h08, 8'h20, 8'h20);
    bus_reset();
    cmd(8'hcc, 1'b0, 8'h00);
    cmd(8'h48, 1'b0, 8'h2a);
    check_rd(8'h07, 8'h80, 8'h80);
    i = 0;
    while (copy_busy !== 1'b0 && i < 40) begin
      @(negedge clk);
      i++;
    end
    check_val(copy_busy, 1'b0);
    // A 20-cycle copy, watched from its second cycle on
    check_val(i, 19);
    if (i == 40) finish_test();
    lock_blk(8'h30, 1'b0);
    lock_blk(8'h3f, 1'b1);
    lock_blk(8'h20, 1'b1);
    power_switch_n = 1'b0;
    @(negedge clk);
    power_switch_n = 1'b1;
    @(negedge clk);
    latch = 1'b0;
    check_all();
    wr(8'h08, 8'h40);
    check_all();
    wr(8'h08, 8'hc0);
    check_all();
    // A low in the same cycle as the host clear must win
    power_switch_n = 1'b0;
    wr(8'h08, 8'hc0);
    power_switch_n = 1'b1;
    latch = 1'b0;
    check_all();
    finish_test();
  end
endmodule : battery_monitor_link_config_status_tb

// [host_line_model.sv]
// Far-side model: pulled-up bus line held by the master, and the general pin wiring
`timescale 1ns/100ps
module host_line_model (
  // Master side
  input wire logic hold_low,
  // Device pin drivers
  input wire logic pin_oe,
  input wire logic pin_out,
  // Resolved levels
  output logic line_level,
  output logic pin_level
);
  // Only the master pulls the line, the device never starts a slot
  // Released line rests high through the pull-up, also while paused
  assign line_level = hold_low ? 1'b0 : 1'b1;
  // Open-drain pin with an external pull-up
  assign pin_level = (pin_oe && !pin_out) ? 1'b0 : 1'b1;
endmodule : host_line_model

// [monitor_link_cfg.sv]
// Configuration and status registers of the battery monitor bus slave
//
// Function
// [R1] Sleep enable 1: line low over 2s enters sleep, line high leaves it.
// [R2] Sleep enable 0: no line driven sleep; read-only, from bit 5 of 31h.
// [R3] Opcode select chooses read-address opcode 33h or 39h.
// [R4] Opcode select read-only, default from bit 4 of config byte 31h.
// [R5] Swap command recognised only while swap enable (bit 3 of 31h) is 1.
// [R6] Copy busy reads 1 during copy; nonvolatile writes are discarded then.
// [R7] Lock command needs lock arm set first; arm clears after lock.
// [R8] Block 1 locked flag shows write protection of 30..3F.
// [R9] Block 0 locked flag shows write protection of 20..2F.
// [R10] Power switch latch catches lows; cleared only by writing 1.
// [R11] Host writes 1 to the latch immediately after reading 0.
// [R12] Swap master flag set when selected by swap with own address.
// [R13] One master on the bus; this device is always a slave.
// [R14] Fixed 64-bit address: family code, 48-bit serial, CRC of 56 bits.
// [R15] CRC sits in the top byte, family code in the bottom byte.
// [R16] Device never checks CRC; host verifies and acts on mismatch.
// [R17] Host CRC: clear register, shift family then serial, LSB first.
// [R18] Open-drain drivers only, pull-up at master, line idles high.
// [R19] Line low over 120us is a reset and abandons any transaction.
// [R20] A pausing master leaves the line released high.
// [R21] Access order: init, address command, function command, data.
// [R22] Init is master reset pulse then presence pulse from slaves.
// [R23] Pin bit 0 drives pin low, 1 releases; sleep or 2s low releases.
// [R24] Host CRC uses polynomial x^8+x^5+x^4+1, LSB first.
// [R25] Reserved bits ignore writes.
`timescale 1ns/100ps
module monitor_link_cfg #(
  parameter int sleep_cycles = monitor_link_pkg::sleep_low_cycles,
  parameter int copy_len = monitor_link_pkg::copy_cycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus line level, already synchronous
  input wire logic line_in,
  // Decoded byte level transactions from the bit engine
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_addr_match,
  input wire logic [7:0] cmd_addr,
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Recall of the stored configuration byte
  input wire logic recall_valid,
  input wire logic [7:0] recall_byte,
  // Pins
  input wire logic power_switch_n,
  input wire logic general_pin_in,
  output logic general_pin_oe,
  output logic general_pin_out,
  // Status to the rest of the device
  output logic [63:0] net_address,
  output logic [7:0] read_addr_opcode,
  output logic swap_accepted,
  output logic sleeping,
  output logic line_reset,
  output logic copy_busy
);
  typedef enum logic [1:0] {
    net_idle = 2'b00,
    net_ready = 2'b01,
    net_func = 2'b10
  } net_state_type;

  function automatic logic [7:0] crc8_calc(input logic [55:0] data);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      if (crc[0] ^ data[i]) begin
        crc = (crc >> 1) ^ 8'h8c;
      end else begin
        crc = crc >> 1;
      end
    end
    return crc;
  endfunction : crc8_calc

  function automatic logic in_nv(input logic [7:0] a);
    return a[7:5] == 3'b001;
  endfunction : in_nv

  function automatic logic [3:0] blk1_hi();
    return monitor_link_pkg::blk1_base[7:4];
  endfunction : blk1_hi

  function automatic logic [3:0] blk0_hi();
    return monitor_link_pkg::blk0_base[7:4];
  endfunction : blk0_hi

  logic [7:0] config_reg, config_next;
  logic lock_arm_reg, lock_arm_next;
  logic block0_reg, block0_next;
  logic block1_reg, block1_next;
  logic ps_latch_reg, ps_latch_next;
  logic pin_drive_reg, pin_drive_next;
  logic master_reg, master_next;
  logic sleep_reg, sleep_next;
  logic [31:0] low_cnt_reg, low_cnt_next;
  logic [31:0] copy_cnt_reg, copy_cnt_next;
  net_state_type net_reg, net_next;
  logic long_low;
  logic nv_write_ok;

  // Fixed address with its own CRC; the device never checks a CRC   [R14] [R15] [R16]
  assign net_address = {crc8_calc({monitor_link_pkg::serial_number, monitor_link_pkg::family_code}),
    monitor_link_pkg::serial_number, monitor_link_pkg::family_code};
  assign read_addr_opcode = config_reg[monitor_link_pkg::bit_opcode_select] ?
    monitor_link_pkg::op_read_addr1 : monitor_link_pkg::op_read_addr0; // [R3] [R4]
  assign line_reset = low_cnt_reg >= 32'(monitor_link_pkg::reset_low_cycles); // [R19]
  assign long_low = low_cnt_reg >= 32'(sleep_cycles);
  assign copy_busy = copy_cnt_reg != 32'h0000_0000; // [R6]
  assign sleeping = sleep_reg;
  // Only a slave: the pin driver is the only output toward the outside   [R13] [R18]
  assign general_pin_oe = pin_drive_reg; // [R23]
  assign general_pin_out = 1'b0;
  assign nv_write_ok = wr_valid && in_nv(wr_addr) && !copy_busy; // [R6]

  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (line_in) begin
      low_cnt_next = 32'h0000_0000;
    end else if (!(long_low && line_reset)) begin
      // Runs on until both the reset and the long-low marks are passed, whichever is later
      low_cnt_next = low_cnt_reg + 32'h0000_0001;
    end
    sleep_next = sleep_reg;
    if (config_reg[monitor_link_pkg::bit_sleep_enable]) begin
      if (long_low) begin
        sleep_next = 1'b1; // [R1]
      end else if (line_in) begin
        sleep_next = 1'b0; // [R1]
      end
    end else begin
      sleep_next = 1'b0; // [R2]
    end
  end

  // Transaction order tracker: reset, address command, function command   [R21] [R22]
  always_comb begin
    net_next = net_reg;
    swap_accepted = 1'b0;
    master_next = master_reg;
    if (line_reset) begin
      net_next = net_state_type'(2'b00); // [R19]
    end else if (cmd_valid) begin
      unique case (net_reg)
        net_idle: begin
          net_next = net_ready;
        end
        net_ready: begin
          if (cmd_opcode == monitor_link_pkg::op_swap) begin
            if (config_reg[monitor_link_pkg::bit_swap_enable]) begin // [R5]
              swap_accepted = cmd_addr_match;
              master_next = cmd_addr_match; // [R12]
              net_next = net_idle;
            end else begin
              // Refused swap: drop to idle, where the next command moves it back to ready
              net_next = net_idle; // [R5]
            end
          end else if (cmd_opcode == read_addr_opcode || cmd_opcode == monitor_link_pkg::op_skip ||
              (cmd_opcode == monitor_link_pkg::op_match && cmd_addr_match)) begin
            net_next = net_func;
          end else begin
            net_next = net_idle;
          end
        end
        net_func: begin
          net_next = net_idle;
        end
        default: begin
          net_next = net_idle;
        end
      endcase
    end
  end

  always_comb begin
    config_next = config_reg;
    lock_arm_next = lock_arm_reg;
    block0_next = block0_reg;
    block1_next = block1_reg;
    ps_latch_next = ps_latch_reg;
    pin_drive_next = pin_drive_reg;
    copy_cnt_next = copy_cnt_reg;
    if (recall_valid) begin
      config_next = recall_byte & 8'h38; // [R2] [R4] [R5] [R25]
    end
    if (copy_busy) begin
      copy_cnt_next = copy_cnt_reg - 32'h0000_0001; // [R6]
    end
    if (wr_valid && wr_addr == monitor_link_pkg::addr_special) begin
      pin_drive_next = ~wr_data[monitor_link_pkg::bit_general_pin]; // [R23]
      if (wr_data[monitor_link_pkg::bit_power_switch]) begin
        ps_latch_next = 1'b1; // [R10]
      end
    end
    if (cmd_valid && net_reg == net_func) begin
      if (cmd_opcode == monitor_link_pkg::op_lock && lock_arm_reg) begin // [R7]
        lock_arm_next = 1'b0;
        if (cmd_addr[7:4] == blk1_hi()) begin
          block1_next = 1'b1; // [R8]
        end else if (cmd_addr[7:4] == blk0_hi()) begin
          block0_next = 1'b1; // [R9]
        end
      end
      if (cmd_opcode == monitor_link_pkg::op_copy && in_nv(cmd_addr) && !copy_busy &&
          !(cmd_addr[4] ? block1_reg : block0_reg)) begin
        copy_cnt_next = 32'(copy_len);
      end
    end
    // Host arm after the lock clear, so an arm landing with a lock command is kept
    if (wr_valid && wr_addr == monitor_link_pkg::addr_nv_ctrl && wr_data[monitor_link_pkg::bit_lock_arm]) begin
      lock_arm_next = 1'b1; // [R7]
    end
    // Capture after the host clear so a low in the clear cycle is kept
    if (!power_switch_n) begin
      ps_latch_next = 1'b0; // [R10]
    end
    if (sleep_reg || long_low) begin
      pin_drive_next = 1'b0; // [R23]
    end
  end

  // Read mux; reserved bits read as zero   [R25]
  always_comb begin
    unique case (rd_addr)
      monitor_link_pkg::addr_recalled: rd_data = config_reg;
      monitor_link_pkg::addr_nv_ctrl: rd_data = {copy_busy, lock_arm_reg, 4'h0, block1_reg, block0_reg}; // [R8] [R9]
      monitor_link_pkg::addr_special: rd_data = {ps_latch_reg, general_pin_in, master_reg, 5'h00}; // [R12]
      default: rd_data = 8'hff;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= monitor_link_pkg::config_byte_reset;
      lock_arm_reg <= 1'b0;
      block0_reg <= 1'b0;
      block1_reg <= 1'b0;
      ps_latch_reg <= 1'b1;
      pin_drive_reg <= 1'b0;
      master_reg <= 1'b0;
      sleep_reg <= 1'b0;
      low_cnt_reg <= 32'h0000_0000;
      copy_cnt_reg <= 32'h0000_0000;
      net_reg <= net_idle;
    end else begin
      config_reg <= config_next;
      lock_arm_reg <= lock_arm_next;
      block0_reg <= block0_next;
      block1_reg <= block1_next;
      ps_latch_reg <= ps_latch_next;
      pin_drive_reg <= pin_drive_next;
      master_reg <= master_next;
      sleep_reg <= sleep_next;
      low_cnt_reg <= low_cnt_next;
      copy_cnt_reg <= copy_cnt_next;
      net_reg <= net_next;
    end
  end

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (config_reg[monitor_link_pkg::bit_sleep_enable] && long_low) |=> sleeping)
    else $error("sleep not entered after long low");
  chk_sleep_disabled: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    !config_reg[monitor_link_pkg::bit_sleep_enable] |=> !sleeping)
    else $error("sleep while disabled");
  chk_opcode_select: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    read_addr_opcode == (config_reg[4] ? 8'h39 : 8'h33))
    else $error("wrong read address opcode");
  chk_swap_gate: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    swap_accepted |-> config_reg[monitor_link_pkg::bit_swap_enable])
    else $error("swap accepted while disabled");
  chk_copy_busy_write: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    copy_busy |-> !nv_write_ok)
    else $error("nv write during copy");
  chk_lock_arm_clear: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    (cmd_valid && net_reg == net_func && cmd_opcode == monitor_link_pkg::op_lock && lock_arm_reg) |=> !lock_arm_reg)
    else $error("lock arm not cleared");
  chk_lock_needs_arm: assert property (@(posedge clk) disable iff (!reset_n) // [R8] [R9]
    ($rose(block0_reg) || $rose(block1_reg)) |-> $past(lock_arm_reg))
    else $error("block locked without arm");
  chk_ps_capture: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    !power_switch_n |=> !ps_latch_reg)
    else $error("power switch low not latched");
  chk_pin_release: assert property (@(posedge clk) disable iff (!reset_n) // [R23]
    sleeping |=> !general_pin_oe)
    else $error("pin driven in sleep");
  chk_line_reset: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
    line_reset |=> net_reg == net_idle)
    else $error("transaction kept after line reset");
  chk_sleep_exit: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (sleeping && line_in && !long_low) |=> !sleeping)
    else $error("sleep kept after line high");
  chk_config_recall: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    recall_valid |=> config_reg == ($past(recall_byte) & 8'h38))
    else $error("recalled configuration not loaded");
  chk_config_readonly: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    !recall_valid |=> $stable(config_reg))
    else $error("status bits changed without recall");
  chk_swap_master: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    swap_accepted |=> master_reg)
    else $error("swap master flag not set");
  chk_swap_refused: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    (cmd_valid && !line_reset && net_reg == net_ready && cmd_opcode == monitor_link_pkg::op_swap &&
      !config_reg[monitor_link_pkg::bit_swap_enable]) |=> net_reg == net_idle)
    else $error("refused swap left the tracker busy");
  chk_copy_start: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    (cmd_valid && net_reg == net_func && cmd_opcode == monitor_link_pkg::op_copy && in_nv(cmd_addr) &&
      !copy_busy && !(cmd_addr[4] ? block1_reg : block0_reg)) |=> copy_busy)
    else $error("copy not started");
  chk_lock_ignored: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    (cmd_valid && cmd_opcode == monitor_link_pkg::op_lock && !lock_arm_reg) |=>
      ($stable(block0_reg) && $stable(block1_reg)))
    else $error("lock taken without arm");
  chk_lock_block1: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    (cmd_valid && net_reg == net_func && cmd_opcode == monitor_link_pkg::op_lock && lock_arm_reg &&
      cmd_addr[7:4] == blk1_hi()) |=> block1_reg)
    else $error("block 1 lock not taken");
  chk_lock_block0: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    (cmd_valid && net_reg == net_func && cmd_opcode == monitor_link_pkg::op_lock && lock_arm_reg &&
      cmd_addr[7:4] == blk0_hi()) |=> block0_reg)
    else $error("block 0 lock not taken");
  chk_block1_sticky: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    block1_reg |=> block1_reg)
    else $error("block 1 lock lost");
  chk_block0_sticky: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    block0_reg |=> block0_reg)
    else $error("block 0 lock lost");
  chk_latch_clear: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    (wr_valid && wr_addr == monitor_link_pkg::addr_special && wr_data[monitor_link_pkg::bit_power_switch] &&
      power_switch_n) |=> ps_latch_reg)
    else $error("power switch latch not cleared");
  chk_latch_write_zero: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    (wr_valid && wr_addr == monitor_link_pkg::addr_special && !wr_data[monitor_link_pkg::bit_power_switch] &&
      power_switch_n) |=> $stable(ps_latch_reg))
    else $error("power switch latch changed by zero write");
  chk_pin_drive: assert property (@(posedge clk) disable iff (!reset_n) // [R23]
    (wr_valid && wr_addr == monitor_link_pkg::addr_special && !wr_data[monitor_link_pkg::bit_general_pin] &&
      !sleep_reg && !long_low) |=> general_pin_oe)
    else $error("pin driver not enabled");
  chk_pin_long_low: assert property (@(posedge clk) disable iff (!reset_n) // [R23]
    long_low |=> !general_pin_oe)
    else $error("pin driven during long low");
  chk_reset_detect: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
    (!line_in && low_cnt_reg == 32'(monitor_link_pkg::reset_low_cycles - 1)) |=> line_reset)
    else $error("reset pulse not detected");
  chk_reset_release: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
    line_in |=> !line_reset)
    else $error("reset held after line high");
endmodule : monitor_link_cfg

// [monitor_link_pkg.sv]
// Constants for the battery monitor link configuration and status block
package monitor_link_pkg;
  localparam logic [7:0] addr_recalled = 8'h01;
  localparam logic [7:0] addr_nv_ctrl = 8'h07;
  localparam logic [7:0] addr_special = 8'h08;
  localparam logic [7:0] addr_config_byte = 8'h31;
  localparam logic [7:0] blk0_base = 8'h20;
  localparam logic [7:0] blk1_base = 8'h30;
  localparam int bit_sleep_enable = 5;
  localparam int bit_opcode_select = 4;
  localparam int bit_swap_enable = 3;
  localparam int bit_copy_busy = 7;
  localparam int bit_lock_arm = 6;
  localparam int bit_block1_locked = 1;
  localparam int bit_block0_locked = 0;
  localparam int bit_power_switch = 7;
  localparam int bit_general_pin = 6;
  localparam int bit_swap_master = 5;
  localparam logic [7:0] op_read_addr0 = 8'h33;
  localparam logic [7:0] op_read_addr1 = 8'h39;
  localparam logic [7:0] op_match = 8'h55;
  localparam logic [7:0] op_skip = 8'hcc;
  localparam logic [7:0] op_swap = 8'haa;
  localparam logic [7:0] op_read_data = 8'h69;
  localparam logic [7:0] op_write_data = 8'h6c;
  localparam logic [7:0] op_copy = 8'h48;
  localparam logic [7:0] op_lock = 8'h6a;
  localparam int clk_mhz = 100;
  localparam int reset_low_us = 120;
  localparam int sleep_low_ms = 2000;
  localparam int reset_low_cycles = reset_low_us * clk_mhz + 1;
  localparam int sleep_low_cycles = sleep_low_ms * 1000 * clk_mhz + 1;
  localparam int copy_time_us = 2000;
  localparam int copy_cycles = copy_time_us * clk_mhz;
  localparam logic [7:0] family_code = 8'h5a;
  localparam logic [47:0] serial_number = 48'h0000_0000_0001;
  localparam logic [7:0] config_byte_reset = 8'h00;
endpackage : monitor_link_pkg
